// ==== verilog/cmpc_defines.svh ====
`ifndef CMPC_DEFINES_SVH
`define CMPC_DEFINES_SVH

// Register byte offsets
`define CMPC_OFS_SFIO     8'h00
`define CMPC_OFS_CSR      8'h04
`define CMPC_OFS_IRQ_STAT 8'h08
`define CMPC_OFS_IRQ_MASK 8'h0C
`define CMPC_OFS_MASK     8'hFC

// Special function register fields
`define CMPC_SF_TRIG_HI   7
`define CMPC_SF_TRIG_LO   5
`define CMPC_SF_UNUSED    4
`define CMPC_SF_MUXEN     3
`define CMPC_SF_PULLDIS   2
`define CMPC_SF_PSR_B     1
`define CMPC_SF_PSR_A     0
`define CMPC_SF_RESET     8'h00

// Comparator control and status fields
`define CMPC_CS_DISABLE   7
`define CMPC_CS_BANDGAP   6
`define CMPC_CS_OUT       5
`define CMPC_CS_FLAG      4
`define CMPC_CS_IRQEN     3
`define CMPC_CS_CAPEN     2
`define CMPC_CS_MODE_HI   1
`define CMPC_CS_MODE_LO   0

// Interrupt status and mask fields
`define CMPC_IRQ_EVENT    0
`define CMPC_IRQ_CHANGE   1
`define CMPC_IRQ_W        2
`define CMPC_IRQ_RESET    2'h0

`define CMPC_CHANNELS     8
`define CMPC_RESP_OKAY    2'h0
`define CMPC_RESP_SLVERR  2'h2

`endif

// ==== verilog/cmpc_pkg.sv ====
`default_nettype none
package cmpc_pkg;
   typedef enum logic [1:0]
   {
      CMPC_MODE_TOGGLE,
      CMPC_MODE_RSVD,
      CMPC_MODE_FALL,
      CMPC_MODE_RISE
   } cmpc_mode_t;
endpackage : cmpc_pkg
`default_nettype wire

// ==== verilog/cmpc_sync_edge.sv ====
`timescale 1ns/1ps
`default_nettype none
module cmpc_sync_edge
(
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic async_in,
   output logic      sync_out,
   output logic      rise,
   output logic      fall
);
   logic meta_r;
   logic sync_r;
   logic prev_r;

   // First stage feeds only the second
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
      end
      else
      begin
         meta_r <= async_in;
         sync_r <= meta_r;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         prev_r <= 1'b0;
      else
         prev_r <= sync_r;
   end

   assign sync_out = sync_r;
   assign rise     = sync_r & ~prev_r;
   assign fall     = ~sync_r & prev_r;
endmodule : cmpc_sync_edge
`default_nettype wire

// ==== verilog/cmpc_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "cmpc_defines.svh"
module cmpc_top
#(
   parameter int CHANNELS = `CMPC_CHANNELS
)
(
   input  wire logic                aclk,
   input  wire logic                aresetn,
   input  wire logic [7:0]          s_axi_awaddr,
   input  wire logic [2:0]          s_axi_awprot,
   input  wire logic                s_axi_awvalid,
   output logic                     s_axi_awready,
   input  wire logic [31:0]         s_axi_wdata,
   input  wire logic [3:0]          s_axi_wstrb,
   input  wire logic                s_axi_wvalid,
   output logic                     s_axi_wready,
   output logic [1:0]               s_axi_bresp,
   output logic                     s_axi_bvalid,
   input  wire logic                s_axi_bready,
   input  wire logic [7:0]          s_axi_araddr,
   input  wire logic [2:0]          s_axi_arprot,
   input  wire logic                s_axi_arvalid,
   output logic                     s_axi_arready,
   output logic [31:0]              s_axi_rdata,
   output logic [1:0]               s_axi_rresp,
   output logic                     s_axi_rvalid,
   input  wire logic                s_axi_rready,
   input  wire logic                comparator_raw,
   input  wire logic                adc_enable_bit,
   input  wire logic [2:0]          neg_input_select,
   input  wire logic                global_irq_enable,
   input  wire logic                irq_vector_ack,
   output logic                     comparator_power_off,
   output logic                     pos_bandgap_sel,
   output logic                     neg_pin_sel,
   output logic [CHANNELS-1:0]      neg_channel_sel,
   output logic                     capture_trigger,
   output logic                     comparator_irq_req,
   output logic                     irq
);
   logic [7:0]            sfio_r;
   logic [7:0]            csr_r;
   logic                  flag_r;
   logic [`CMPC_IRQ_W-1:0] istat_r;
   logic [`CMPC_IRQ_W-1:0] imask_r;
   logic                  pwr_off_r;
   logic                  bandgap_r;
   logic                  neg_pin_r;
   logic [CHANNELS-1:0]   chan_r;
   logic                  capture_r;
   logic                  aw_held_r;
   logic                  w_held_r;
   logic [7:0]            waddr_r;
   logic [31:0]           wdata_r;
   logic [3:0]            wstrb_r;
   logic                  bvalid_r;
   logic [1:0]            bresp_r;
   logic                  rvalid_r;
   logic [1:0]            rresp_r;
   logic [31:0]           rdata_r;
   logic                  cmp_sync;
   logic                  cmp_rise;
   logic                  cmp_fall;
   logic                  cmp_event;
   logic                  use_mux;
   logic                  wr_go;
   logic                  wr_lane0;
   logic [7:0]            wr_ofs;
   logic [7:0]            rd_ofs;
   logic [7:0]            csr_rd;
   cmpc_pkg::cmpc_mode_t  mode;

   cmpc_sync_edge u_sync
   (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .async_in (comparator_raw),
      .sync_out (cmp_sync),
      .rise     (cmp_rise),
      .fall     (cmp_fall)
   );

   assign mode = cmpc_pkg::cmpc_mode_t'(csr_r[`CMPC_CS_MODE_HI:`CMPC_CS_MODE_LO]);

   // Mode change glitches are left to software, which masks first
   always_comb
   begin
      unique case (mode)
         cmpc_pkg::CMPC_MODE_TOGGLE: cmp_event = cmp_rise | cmp_fall;
         cmpc_pkg::CMPC_MODE_FALL:   cmp_event = cmp_fall;
         cmpc_pkg::CMPC_MODE_RISE:   cmp_event = cmp_rise;
         cmpc_pkg::CMPC_MODE_RSVD:   cmp_event = 1'b0;
      endcase
   end

   // Write channel: address and data taken in either order
   assign s_axi_awready = !aw_held_r && !bvalid_r;
   assign s_axi_wready  = !w_held_r && !bvalid_r;
   assign wr_go         = aw_held_r && w_held_r && !bvalid_r;
   assign wr_ofs        = waddr_r & `CMPC_OFS_MASK;
   assign wr_lane0      = wr_go && wstrb_r[0];

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held_r <= 1'b0;
         waddr_r   <= 8'h00;
      end
      else if (s_axi_awvalid && s_axi_awready)
      begin
         aw_held_r <= 1'b1;
         waddr_r   <= s_axi_awaddr;
      end
      else if (wr_go)
         aw_held_r <= 1'b0;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         w_held_r <= 1'b0;
         wdata_r  <= 32'h0000_0000;
         wstrb_r  <= 4'h0;
      end
      else if (s_axi_wvalid && s_axi_wready)
      begin
         w_held_r <= 1'b1;
         wdata_r  <= s_axi_wdata;
         wstrb_r  <= s_axi_wstrb;
      end
      else if (wr_go)
         w_held_r <= 1'b0;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bvalid_r <= 1'b0;
         bresp_r  <= `CMPC_RESP_OKAY;
      end
      else if (wr_go)
      begin
         bvalid_r <= 1'b1;
         unique case (wr_ofs)
            `CMPC_OFS_SFIO, `CMPC_OFS_CSR, `CMPC_OFS_IRQ_STAT, `CMPC_OFS_IRQ_MASK:
               bresp_r <= `CMPC_RESP_OKAY;
            default:
               bresp_r <= `CMPC_RESP_SLVERR;
         endcase
      end
      else if (s_axi_bready)
         bvalid_r <= 1'b0;
   end

   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp  = bresp_r;

   // Bit four stays zero; other bits plain storage
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         sfio_r <= `CMPC_SF_RESET;
      else if (wr_lane0 && wr_ofs == `CMPC_OFS_SFIO)
      begin
         sfio_r                 <= wdata_r[7:0];
         sfio_r[`CMPC_SF_UNUSED] <= 1'b0;
      end
   end

   // Output and flag bits of csr_r are unused; they live elsewhere
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         csr_r <= 8'h00;
      else if (wr_lane0 && wr_ofs == `CMPC_OFS_CSR)
      begin
         csr_r                <= wdata_r[7:0];
         csr_r[`CMPC_CS_OUT]  <= 1'b0;
         csr_r[`CMPC_CS_FLAG] <= 1'b0;
      end
   end

   // Set wins over both clears so no event is lost
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         flag_r <= 1'b0;
      else if (cmp_event)
         flag_r <= 1'b1;
      else if (irq_vector_ack)
         flag_r <= 1'b0;
      else if (wr_lane0 && wr_ofs == `CMPC_OFS_CSR && wdata_r[`CMPC_CS_FLAG])
         flag_r <= 1'b0;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         istat_r <= `CMPC_IRQ_RESET;
      else
      begin
         for (int i = 0; i < `CMPC_IRQ_W; i++)
         begin
            if ((i == `CMPC_IRQ_EVENT && cmp_event) ||
                (i == `CMPC_IRQ_CHANGE && (cmp_rise || cmp_fall)))
               istat_r[i] <= 1'b1;
            else if (wr_lane0 && wr_ofs == `CMPC_OFS_IRQ_STAT && wdata_r[i])
               istat_r[i] <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         imask_r <= `CMPC_IRQ_RESET;
      else if (wr_lane0 && wr_ofs == `CMPC_OFS_IRQ_MASK)
         imask_r <= wdata_r[`CMPC_IRQ_W-1:0];
   end

   assign irq = |(istat_r & imask_r);
   assign comparator_irq_req = flag_r && csr_r[`CMPC_CS_IRQEN] && global_irq_enable;

   // Analog selects registered to keep the switches glitch free
   assign use_mux = sfio_r[`CMPC_SF_MUXEN] && !adc_enable_bit;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pwr_off_r <= 1'b0;
         bandgap_r <= 1'b0;
         neg_pin_r <= 1'b1;
         capture_r <= 1'b0;
      end
      else
      begin
         pwr_off_r <= csr_r[`CMPC_CS_DISABLE];
         bandgap_r <= csr_r[`CMPC_CS_BANDGAP];
         neg_pin_r <= !use_mux;
         capture_r <= csr_r[`CMPC_CS_CAPEN] && cmp_sync;
      end
   end

   for (genvar c = 0; c < CHANNELS; c++)
   begin : g_chan
      always_ff @(posedge aclk)
      begin
         if (!aresetn)
            chan_r[c] <= 1'b0;
         else
            chan_r[c] <= use_mux && (neg_input_select == 3'(c));
      end
   end

   assign comparator_power_off = pwr_off_r;
   assign pos_bandgap_sel      = bandgap_r;
   assign neg_pin_sel          = neg_pin_r;
   assign neg_channel_sel      = chan_r;
   assign capture_trigger      = capture_r;

   // Read channel: one outstanding read, answer one cycle after address
   assign s_axi_arready = !rvalid_r;
   assign rd_ofs        = s_axi_araddr & `CMPC_OFS_MASK;

   always_comb
   begin
      csr_rd               = csr_r;
      csr_rd[`CMPC_CS_OUT]  = cmp_sync;
      csr_rd[`CMPC_CS_FLAG] = flag_r;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid_r <= 1'b0;
         rresp_r  <= `CMPC_RESP_OKAY;
         rdata_r  <= 32'h0000_0000;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         rvalid_r <= 1'b1;
         rresp_r  <= `CMPC_RESP_OKAY;
         rdata_r  <= 32'h0000_0000;
         unique case (rd_ofs)
            `CMPC_OFS_SFIO:     rdata_r[7:0] <= sfio_r;
            `CMPC_OFS_CSR:      rdata_r[7:0] <= csr_rd;
            `CMPC_OFS_IRQ_STAT: rdata_r[`CMPC_IRQ_W-1:0] <= istat_r;
            `CMPC_OFS_IRQ_MASK: rdata_r[`CMPC_IRQ_W-1:0] <= imask_r;
            default:            rresp_r <= `CMPC_RESP_SLVERR;
         endcase
      end
      else if (s_axi_rready)
         rvalid_r <= 1'b0;
   end

   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rresp  = rresp_r;
   assign s_axi_rdata  = rdata_r;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_mux_route;
      sfio_r[`CMPC_SF_MUXEN] && !adc_enable_bit |=> !neg_pin_sel && $onehot(neg_channel_sel);
   endproperty
   a_mux_route: assert property (p_mux_route) else $error("mux not routed");

   property p_pin_route;
      !sfio_r[`CMPC_SF_MUXEN] || adc_enable_bit |=> neg_pin_sel && neg_channel_sel == '0;
   endproperty
   a_pin_route: assert property (p_pin_route) else $error("pin not routed");

   property p_chan_pick;
      use_mux |=> neg_channel_sel[$past(neg_input_select)];
   endproperty
   a_chan_pick: assert property (p_chan_pick) else $error("wrong channel");

   property p_power;
      ##1 comparator_power_off == $past(csr_r[`CMPC_CS_DISABLE]);
   endproperty
   a_power: assert property (p_power) else $error("power select lag");

   property p_bandgap;
      ##1 pos_bandgap_sel == $past(csr_r[`CMPC_CS_BANDGAP]);
   endproperty
   a_bandgap: assert property (p_bandgap) else $error("bandgap select lag");

   property p_sync;
      ##2 cmp_sync == $past(comparator_raw, 2);
   endproperty
   a_sync: assert property (p_sync) else $error("sync latency wrong");

   property p_flag_set;
      cmp_event |=> flag_r;
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("flag not set");

   property p_flag_clr;
      irq_vector_ack && !cmp_event |=> !flag_r;
   endproperty
   a_flag_clr: assert property (p_flag_clr) else $error("flag not cleared");

   property p_req;
      comparator_irq_req == (flag_r && csr_r[`CMPC_CS_IRQEN] && global_irq_enable);
   endproperty
   a_req: assert property (p_req) else $error("request mismatch");

   property p_capture;
      !csr_r[`CMPC_CS_CAPEN] |=> !capture_trigger;
   endproperty
   a_capture: assert property (p_capture) else $error("capture leaks");

   property p_fall_mode;
      mode == cmpc_pkg::CMPC_MODE_FALL && cmp_sync && !flag_r && !irq_vector_ack |=> !flag_r;
   endproperty
   a_fall_mode: assert property (p_fall_mode) else $error("rise in fall mode");

   property p_sf_unused;
      !sfio_r[`CMPC_SF_UNUSED];
   endproperty
   a_sf_unused: assert property (p_sf_unused) else $error("unused bit set");

   property p_toggle;
      mode == cmpc_pkg::CMPC_MODE_TOGGLE && $changed(cmp_sync) |-> cmp_event;
   endproperty
   a_toggle: assert property (p_toggle) else $error("toggle missed");

   property p_reserved;
      mode == cmpc_pkg::CMPC_MODE_RSVD && !irq_vector_ack && !wr_lane0 |=> $stable(flag_r);
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved mode event");

   property p_wr_resp;
      wr_go |=> s_axi_bvalid;
   endproperty
   a_wr_resp: assert property (p_wr_resp) else $error("no write response");

   c_event_irq: cover property (cmp_event ##1 comparator_irq_req);
   c_vector_clr: cover property (flag_r ##1 irq_vector_ack ##1 !flag_r);
   c_mux_path: cover property (use_mux ##1 !neg_pin_sel);
   c_rise_mode: cover property (mode == cmpc_pkg::CMPC_MODE_RISE && cmp_rise);
endmodule : cmpc_top
`default_nettype wire

// ==== verif/cmpc_analog_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module cmpc_analog_model
#(
   parameter logic [15:0] BANDGAP_MV = 16'h04CE
)
(
   input  wire logic             aclk,
   input  wire logic             aresetn,
   input  wire logic             power_off,
   input  wire logic             bandgap_sel,
   input  wire logic             neg_pin_sel,
   input  wire logic [7:0]       chan_sel,
   input  wire logic             capture_in,
   input  wire logic             capture_irq_enable,
   input  wire logic [15:0]      pos_mv,
   input  wire logic [15:0]      neg_mv,
   input  wire logic [7:0][15:0] chan_mv,
   output logic                  raw,
   output logic                  capture_irq
);
   logic [15:0] neg;
   logic        cap_q;
   always_comb
   begin
      neg = neg_pin_sel ? neg_mv : 16'hFFFF;
      for (int i = 0; i < 8; i++)
         if (chan_sel[i])
            neg = chan_mv[i];
      // Unpowered core settles low
      raw = !power_off && ((bandgap_sel ? BANDGAP_MV : pos_mv) > neg);
   end
   // Timer side needs its own enable
   always @(posedge aclk)
   begin
      cap_q <= capture_in;
      if (!aresetn)
         capture_irq <= 1'b0;
      else if (capture_irq_enable && capture_in && !cap_q)
         capture_irq <= 1'b1;
   end
endmodule : cmpc_analog_model
`default_nettype wire

// ==== verif/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "cmpc_defines.svh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
   $display("BAD %s exp %0h got %0h", n, e, g); end end
module tb;
   logic             aclk = 1'b0;
   logic             aresetn = 1'b0;
   logic [7:0]       awaddr = 8'h00, araddr = 8'h00;
   logic             awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic             arvalid = 1'b0, rready = 1'b0;
   logic             adc_en = 1'b0, gie = 1'b0, ack = 1'b0, cap_ie = 1'b0;
   logic [31:0]      wdata = 32'h0, rdv;
   logic [2:0]       nsel = 3'h0;
   logic [1:0]       bresp_q, rresp_q;
   logic [15:0]      pos_mv = 16'h0000, neg_mv = 16'h01F4;
   logic [7:0][15:0] chan_mv = '0;
   wire              awready, wready, bvalid, arready, rvalid, raw, pwr_off, bg, npin;
   wire              capt, irq_req, irq, cap_irq;
   wire [1:0]        bresp, rresp;
   wire [31:0]       rdata;
   wire [7:0]        chsel;
   int               n_mismatch = 0, total_checks = 0;

   cmpc_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .comparator_raw(raw), .adc_enable_bit(adc_en), .neg_input_select(nsel),
      .global_irq_enable(gie), .irq_vector_ack(ack), .comparator_power_off(pwr_off),
      .pos_bandgap_sel(bg), .neg_pin_sel(npin), .neg_channel_sel(chsel),
      .capture_trigger(capt), .comparator_irq_req(irq_req), .irq(irq));
   cmpc_analog_model model (.aclk(aclk), .aresetn(aresetn), .power_off(pwr_off),
      .bandgap_sel(bg), .neg_pin_sel(npin), .chan_sel(chsel), .capture_in(capt),
      .capture_irq_enable(cap_ie), .pos_mv(pos_mv), .neg_mv(neg_mv), .chan_mv(chan_mv),
      .raw(raw), .capture_irq(cap_irq));

   initial
   begin
      forever #2.5 aclk = ~aclk;
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask : cyc

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bit done;
      done = 0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      // Only the watchdog ends a wait for the slave
      while (!done)
      begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid && bready)
         begin
            bresp_q = bresp;
            bready <= 1'b0;
            done = 1;
         end
      end
   endtask : wr

   task automatic rc(input logic [7:0] a, input logic [31:0] e, input string n);
      bit done;
      done = 0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!done)
      begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid && rready)
         begin
            rdv = rdata;
            rresp_q = rresp;
            rready <= 1'b0;
            done = 1;
         end
      end
      `CHK(n, e, rdv)
   endtask : rc

   task automatic t_reset;
      rc(`CMPC_OFS_SFIO, 32'h0, "sfio rst");
      rc(`CMPC_OFS_CSR, 32'h0, "csr rst");
      `CHK("neg pin", 1'b1, npin)
      rc(8'h10, 32'h0, "unmapped");
      `CHK("rresp", `CMPC_RESP_SLVERR, rresp_q)
      wr(8'h14, 32'hFF);
      `CHK("bresp", `CMPC_RESP_SLVERR, bresp_q)
   endtask : t_reset

   task automatic t_mux;
      wr(`CMPC_OFS_SFIO, 32'hFF);
      rc(`CMPC_OFS_SFIO, 32'hEF, "sfio ro");
      for (int i = 0; i < 8; i++)
      begin
         nsel <= 3'(i);
         cyc(3);
         `CHK("chan", 8'h01 << i, chsel)
         `CHK("pin off", 1'b0, npin)
      end
      adc_en <= 1'b1;
      cyc(3);
      `CHK("pin adc", 1'b1, npin)
      `CHK("chan adc", 8'h00, chsel)
      adc_en <= 1'b0;
      wr(`CMPC_OFS_SFIO, 32'h0);
      cyc(2);
      `CHK("pin mux0", 1'b1, npin)
   endtask : t_mux

   task automatic t_pos;
      // Irq enable already clear here
      wr(`CMPC_OFS_CSR, 32'hC0);
      cyc(2);
      `CHK("pwr off", 1'b1, pwr_off)
      `CHK("bandgap", 1'b1, bg)
      wr(`CMPC_OFS_CSR, 32'h0);
      cyc(2);
      `CHK("bandgap off", 1'b0, bg)
   endtask : t_pos

   task automatic t_mode;
      logic [31:0] f;
      for (int m = 0; m < 4; m++)
      begin
         wr(`CMPC_OFS_CSR, 32'(m) | 32'h10);
         pos_mv <= 16'h03E8;
         cyc(4);
         f = (m == 0 || m == 3) ? 32'h10 : 32'h0;
         rc(`CMPC_OFS_CSR, 32'h20 | f | 32'(m), "rise");
         wr(`CMPC_OFS_CSR, 32'(m) | 32'h10);
         rc(`CMPC_OFS_CSR, 32'h20 | 32'(m), "w1c");
         pos_mv <= 16'h0000;
         cyc(4);
         f = (m == 0 || m == 2) ? 32'h10 : 32'h0;
         rc(`CMPC_OFS_CSR, f | 32'(m), "fall");
      end
      wr(`CMPC_OFS_CSR, 32'h10);
   endtask : t_mode

   task automatic t_irq;
      wr(`CMPC_OFS_CSR, 32'h03);
      wr(`CMPC_OFS_IRQ_STAT, 32'h3);
      wr(`CMPC_OFS_IRQ_MASK, 32'h1);
      gie <= 1'b1;
      pos_mv <= 16'h03E8;
      cyc(4);
      `CHK("req ie0", 1'b0, irq_req)
      `CHK("irq ev", 1'b1, irq)
      wr(`CMPC_OFS_CSR, 32'h0B);
      `CHK("req on", 1'b1, irq_req)
      gie <= 1'b0;
      cyc(1);
      `CHK("req gie0", 1'b0, irq_req)
      gie <= 1'b1;
      ack <= 1'b1;
      cyc(1);
      ack <= 1'b0;
      cyc(1);
      `CHK("req ack", 1'b0, irq_req)
      rc(`CMPC_OFS_IRQ_STAT, 32'h3, "stat");
      wr(`CMPC_OFS_IRQ_STAT, 32'h1);
      `CHK("irq clr", 1'b0, irq)
      wr(`CMPC_OFS_IRQ_MASK, 32'h2);
      `CHK("irq chg", 1'b1, irq)
      wr(`CMPC_OFS_IRQ_STAT, 32'h2);
      `CHK("irq off", 1'b0, irq)
      wr(`CMPC_OFS_CSR, 32'h03);
      wr(`CMPC_OFS_IRQ_MASK, 32'h0);
      pos_mv <= 16'h0000;
      cyc(4);
   endtask : t_irq

   task automatic t_cap;
      wr(`CMPC_OFS_CSR, 32'h04);
      cap_ie <= 1'b1;
      pos_mv <= 16'h03E8;
      // Timer model flags one edge after the trigger rises
      cyc(5);
      `CHK("cap hi", 1'b1, capt)
      `CHK("cap irq", 1'b1, cap_irq)
      wr(`CMPC_OFS_CSR, 32'h0);
      cyc(2);
      `CHK("cap off", 1'b0, capt)
      pos_mv <= 16'h0000;
      cyc(4);
   endtask : t_cap

   task automatic results;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : results

   initial
   begin
      #50000;
      n_mismatch++;
      results();
   end

   initial
   begin
      for (int i = 0; i < 8; i++)
         chan_mv[i] = 16'(i * 100);
      cyc(2);
      aresetn <= 1'b1;
      t_reset();
      t_mux();
      t_pos();
      t_mode();
      t_irq();
      t_cap();
      results();
   end
endmodule : tb
`default_nettype wire
